//--- include/banked_memory_cfg.svh
// Constants for the banked memory address map: vectors, file offsets,
// field positions, reset values and the register bus index map.
// Assumes it is included by the package, the address map design file and the bench files.
`ifndef BANKED_MEMORY_CFG_SVH
`define BANKED_MEMORY_CFG_SVH

`define PC_W 13
`define PROG_AW 12
`define PROG_DEPTH 4096
`define INSTR_W 14
`define RESET_VECTOR 13'h0000
`define IRQ_VECTOR 13'h0004
`define PC_ONE 13'h0001
`define PC_HI_W 5

`define DADDR_W 9
`define OFF_W 7
`define SFR_INDIRECT 7'h00
`define SFR_PCL 7'h02
`define SFR_STATUS 7'h03
`define SFR_FSR 7'h04
`define SFR_PROGRAM_COUNTER_HIGH_LATCH 7'h0A
`define SFR_INTERRUPT_CONTROL 7'h0B
`define GPR_LO 7'h20
`define COMMON_LO 7'h70
`define BANK0 2'h0
`define BANK1 2'h1
`define BANK0_GPR_CNT 8'h60
`define GPR_IDX_W 8
`define GPR_DEPTH 176

`define STATUS_IRP 7
`define STATUS_RP_HI 6
`define STATUS_RP_LO 5
`define STATUS_RST 8'h18
`define BYTE_ZERO 8'h00

`define AXI_AW 12
`define IDX_W 10
`define IDX_OWN_BIT 9
`define IDX_PROG_ADDR 10'h200
`define IDX_PROG_DATA 10'h201
`define IDX_CONTROL 10'h202
`define CTRL_RUN 0
`define CTRL_RST 1'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WORD_ZERO 32'h0000_0000

`endif

//--- include/banked_memory_pkg.sv
// Types shared by the banked memory address map, its core model and its bench.
// Assumes banked_memory_cfg.svh is on the include path.
`include "banked_memory_cfg.svh"

package banked_memory_pkg;

  // Quarter cycles of one instruction cycle
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} qphase_t;

  // What a data file address lands on
  typedef enum logic [2:0] {
    TGT_NONE, TGT_INDIRECT, TGT_PCL, TGT_STATUS,
    TGT_FSR, TGT_PROGRAM_COUNTER_HIGH_LATCH, TGT_INTERRUPT_CONTROL, TGT_GPR
  } target_t;

  // Data access request from the core
  typedef struct packed {
    logic [`OFF_W-1:0] addr;
    logic write;
    logic [7:0] wdata;
  } data_req_t;

  // Decoded target and general purpose RAM index
  typedef struct packed {
    target_t kind;
    logic [`GPR_IDX_W-1:0] index;
  } decode_t;

endpackage : banked_memory_pkg

//--- core/general_ram.sv
// Simple storage array: one synchronous write port, one read port.
// Assumes the caller arbitrates the write port and holds ce for freeze.
`timescale 1ns/1ps

module general_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 176,
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage has no reset, contents are undefined until written
  always_ff @(posedge aclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read is combinational; callers register the result
  assign rdata = mem[raddr];

endmodule : general_ram

//--- core/banked_memory_address_map.sv
// Program and data address map for a small core: program counter,
// program store, banked data file with core registers, AXI4-Lite access.
// Assumes the core shares aclk and drives its requests from flip-flops.
//
// Notes on behaviour
// (RULE1) The program counter is 13 bits, covering 8K words of 14 bits.
// (RULE2) Only program words 0000h to 0FFFh have storage.
// (RULE3) Fetches above 0FFFh wrap onto the implemented words.
// (RULE4) After reset the first fetch is from address 0000h.
// (RULE5) Taking an interrupt loads the program counter with 0004h.
// (RULE6) Status bits 6 and 5 select one of four banks for direct access.
// (RULE7) Bank codes 00 to 11 select 00h, 80h, 100h and 180h upward.
// (RULE8) Low offsets of each bank are core registers, higher ones RAM; banks 2 and 3 have RAM only at 70h to 7Fh.
// (RULE9) Core registers answer at the same offset in every bank.
// (RULE10) Data is reached directly or through the 8-bit pointer.
// (RULE11) Banks 1 to 3 have no own storage in their top sixteen bytes.
// (RULE12) Those top sixteen bytes reach bank 0 locations 70h to 7Fh.
// (RULE13) The operand is read in Q2 and the destination written in Q4.
// (RULE14) Unimplemented data addresses read zero and ignore writes.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "banked_memory_cfg.svh"

module banked_memory_address_map (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [`AXI_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`AXI_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic branch_valid,
  input wire logic [`PC_W-1:0] branch_target,
  input wire logic irq_take,
  input wire banked_memory_pkg::data_req_t data_req,
  output logic [`PC_W-1:0] program_counter,
  output logic [`PROG_AW-1:0] fetch_addr,
  output logic [`INSTR_W-1:0] instr_word,
  output logic instr_valid,
  output logic [7:0] operand_data,
  output logic operand_valid,
  output logic [1:0] bank_select,
  output logic [7:0] interrupt_control
);

  banked_memory_pkg::qphase_t phase_q;
  logic run_q;
  logic [`PC_W-1:0] pc_q;
  logic [7:0] status_q, fsr_q, program_counter_high_latch_q, interrupt_control_q;
  logic [`PROG_AW-1:0] prog_addr_q, fetch_q;
  logic [`INSTR_W-1:0] instr_q, prog_rdata;
  logic instr_valid_q, operand_valid_q;
  logic [7:0] operand_q, ram_rdata, acc_rdata, acc_wdata;
  logic aw_have_q, w_have_q, ar_have_q, bvalid_q, rvalid_q;
  logic [`AXI_AW-1:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic core_slot, axi_sel_wr, axi_wr_go, axi_rd_go, own_sel;
  logic acc_we, data_we, ram_we, pcl_wr, prog_we, byte_ok;
  logic [`IDX_W-1:0] axi_idx;
  logic [`DADDR_W-1:0] acc_raw, acc_eff;
  banked_memory_pkg::decode_t dec;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Map a 9-bit file address onto its target
  function automatic banked_memory_pkg::decode_t decode_addr(
    input logic [`DADDR_W-1:0] a);
    banked_memory_pkg::decode_t d;
    logic [1:0] bank;
    logic [`OFF_W-1:0] off;
    d.kind = banked_memory_pkg::TGT_NONE;
    d.index = `BYTE_ZERO;
    bank = a[`DADDR_W-1:`OFF_W];
    off = a[`OFF_W-1:0];
    // (RULE9) mirrored core registers
    case (off)
      `SFR_INDIRECT: d.kind = banked_memory_pkg::TGT_INDIRECT;
      `SFR_PCL: d.kind = banked_memory_pkg::TGT_PCL;
      `SFR_STATUS: d.kind = banked_memory_pkg::TGT_STATUS;
      `SFR_FSR: d.kind = banked_memory_pkg::TGT_FSR;
      `SFR_PROGRAM_COUNTER_HIGH_LATCH: d.kind = banked_memory_pkg::TGT_PROGRAM_COUNTER_HIGH_LATCH;
      `SFR_INTERRUPT_CONTROL: d.kind = banked_memory_pkg::TGT_INTERRUPT_CONTROL;
      default: begin
        // (RULE11) (RULE12) common top bytes land in bank 0
        if (off >= `COMMON_LO) begin
          d.kind = banked_memory_pkg::TGT_GPR;
          d.index = `GPR_IDX_W'(off - `GPR_LO);
        // (RULE8) RAM above the register block
        end else if (bank == `BANK0 && off >= `GPR_LO) begin
          d.kind = banked_memory_pkg::TGT_GPR;
          d.index = `GPR_IDX_W'(off - `GPR_LO);
        end else if (bank == `BANK1 && off >= `GPR_LO) begin
          d.kind = banked_memory_pkg::TGT_GPR;
          d.index = `BANK0_GPR_CNT + `GPR_IDX_W'(off - `GPR_LO);
        end
      end
    endcase
    return d;
  endfunction : decode_addr

  // Quarter-cycle sequencer, parked at Q1 while halted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= banked_memory_pkg::PH_Q1;
    end else if (ce) begin
      if (!run_q) begin
        phase_q <= banked_memory_pkg::PH_Q1;
      end else begin
        case (phase_q)
          banked_memory_pkg::PH_Q1: phase_q <= banked_memory_pkg::PH_Q2;
          banked_memory_pkg::PH_Q2: phase_q <= banked_memory_pkg::PH_Q3;
          banked_memory_pkg::PH_Q3: phase_q <= banked_memory_pkg::PH_Q4;
          default: phase_q <= banked_memory_pkg::PH_Q1;
        endcase
      end
    end
  end

  // Core owns the data port in Q2 and Q4; the bus gets the other slots
  assign core_slot = run_q && (phase_q == banked_memory_pkg::PH_Q2 ||
                               phase_q == banked_memory_pkg::PH_Q4);
  assign axi_sel_wr = aw_have_q && w_have_q && !bvalid_q;
  assign axi_wr_go = axi_sel_wr && !core_slot;
  assign axi_rd_go = ar_have_q && !rvalid_q && !axi_sel_wr && !core_slot;
  assign axi_idx = axi_sel_wr ? awaddr_q[`AXI_AW-1:2] : araddr_q[`AXI_AW-1:2];
  assign own_sel = !core_slot && axi_idx[`IDX_OWN_BIT];
  assign byte_ok = wstrb_q[0];

  // (RULE6) (RULE7) bank bits extend the direct offset
  assign acc_raw = core_slot ? {status_q[`STATUS_RP_HI:`STATUS_RP_LO],
                                data_req.addr}
                             : axi_idx[`DADDR_W-1:0];
  // (RULE10) indirect port redirects through the pointer
  assign acc_eff = (acc_raw[`OFF_W-1:0] == `SFR_INDIRECT) ?
                   {status_q[`STATUS_IRP], fsr_q} : acc_raw;
  assign dec = decode_addr(acc_eff);

  // (RULE13) core writes only in Q4; bus writes need lane 0
  assign acc_we = core_slot ?
                  (phase_q == banked_memory_pkg::PH_Q4 && data_req.write) :
                  (axi_wr_go && byte_ok);
  assign acc_wdata = core_slot ? data_req.wdata : wdata_q[7:0];
  assign data_we = acc_we && !own_sel;
  assign ram_we = data_we && dec.kind == banked_memory_pkg::TGT_GPR;
  assign pcl_wr = data_we && dec.kind == banked_memory_pkg::TGT_PCL;
  assign prog_we = axi_wr_go && axi_idx == `IDX_PROG_DATA &&
                   wstrb_q[1:0] == 2'h3;

  // (RULE14) unmapped and indirect-of-indirect read as zero
  always_comb begin
    case (dec.kind)
      banked_memory_pkg::TGT_PCL: acc_rdata = pc_q[7:0];
      banked_memory_pkg::TGT_STATUS: acc_rdata = status_q;
      banked_memory_pkg::TGT_FSR: acc_rdata = fsr_q;
      banked_memory_pkg::TGT_PROGRAM_COUNTER_HIGH_LATCH: acc_rdata = program_counter_high_latch_q;
      banked_memory_pkg::TGT_INTERRUPT_CONTROL: acc_rdata = interrupt_control_q;
      banked_memory_pkg::TGT_GPR: acc_rdata = ram_rdata;
      default: acc_rdata = `BYTE_ZERO;
    endcase
  end

  general_ram #(.WIDTH(8), .DEPTH(`GPR_DEPTH), .AW(`GPR_IDX_W)) u_file_ram (
    .aclk(aclk),
    .ce(ce),
    .we(ram_we),
    .waddr(dec.index),
    .wdata(acc_wdata),
    .raddr(dec.index),
    .rdata(ram_rdata)
  );

  // (RULE2) program store holds only the low 4K words
  general_ram #(.WIDTH(`INSTR_W), .DEPTH(`PROG_DEPTH), .AW(`PROG_AW))
  u_prog_ram (
    .aclk(aclk),
    .ce(ce),
    .we(prog_we),
    .waddr(prog_addr_q),
    .wdata(wdata_q[`INSTR_W-1:0]),
    .raddr(fetch_addr),
    .rdata(prog_rdata)
  );

  // Core registers written by the core or the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= `STATUS_RST;
      fsr_q <= `BYTE_ZERO;
      program_counter_high_latch_q <= `BYTE_ZERO;
      interrupt_control_q <= `BYTE_ZERO;
    end else if (ce && data_we) begin
      case (dec.kind)
        banked_memory_pkg::TGT_STATUS: status_q <= acc_wdata;
        banked_memory_pkg::TGT_FSR: fsr_q <= acc_wdata;
        banked_memory_pkg::TGT_PROGRAM_COUNTER_HIGH_LATCH: program_counter_high_latch_q <= acc_wdata;
        banked_memory_pkg::TGT_INTERRUPT_CONTROL: interrupt_control_q <= acc_wdata;
        default: ;
      endcase
    end
  end

  // Program counter; the interrupt vector wins over all else
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // (RULE4) start from the reset vector
      pc_q <= `RESET_VECTOR;
    end else if (ce) begin
      // (RULE5) interrupt vector load
      if (run_q && phase_q == banked_memory_pkg::PH_Q1 && irq_take) begin
        pc_q <= `IRQ_VECTOR;
      end else if (pcl_wr) begin
        pc_q <= {program_counter_high_latch_q[`PC_HI_W-1:0], acc_wdata};
      // (RULE1) 13-bit advance, rolls over at 1FFFh
      end else if (run_q && phase_q == banked_memory_pkg::PH_Q1) begin
        pc_q <= branch_valid ? branch_target : pc_q + `PC_ONE;
      end
    end
  end

  // (RULE3) upper half of the space aliases the low 4K; the fetch uses
  // the pc held before this cycle's Q1 advance, so the first word is 0000h
  assign fetch_addr = fetch_q;

  // Fetch latched in Q4 before the next Q1 advance, operand in Q2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_q <= '0;
      instr_valid_q <= 1'b0;
      operand_q <= `BYTE_ZERO;
      operand_valid_q <= 1'b0;
      fetch_q <= '0;
    end else if (ce) begin
      // (RULE4) fetch address taken before the pc advances
      if (run_q && phase_q == banked_memory_pkg::PH_Q1) begin
        fetch_q <= pc_q[`PROG_AW-1:0];
      end
      instr_valid_q <= run_q && phase_q == banked_memory_pkg::PH_Q4;
      if (run_q && phase_q == banked_memory_pkg::PH_Q4) begin
        instr_q <= prog_rdata;
      end
      // (RULE13) operand read slot
      operand_valid_q <= run_q && phase_q == banked_memory_pkg::PH_Q2;
      if (run_q && phase_q == banked_memory_pkg::PH_Q2) begin
        operand_q <= acc_rdata;
      end
    end
  end

  // Loader pointer auto-increments so a program streams in word by word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_addr_q <= '0;
      run_q <= `CTRL_RST;
    end else if (ce && axi_wr_go) begin
      if (axi_idx == `IDX_PROG_ADDR && wstrb_q[1:0] == 2'h3) begin
        prog_addr_q <= wdata_q[`PROG_AW-1:0];
      end else if (prog_we) begin
        prog_addr_q <= prog_addr_q + `PROG_AW'(1);
      end else if (axi_idx == `IDX_CONTROL && byte_ok) begin
        run_q <= wdata_q[`CTRL_RUN];
      end
    end
  end

  // Bus write channels are taken independently, then applied together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= `WORD_ZERO;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (axi_wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (axi_idx > `IDX_CONTROL) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Bus reads wait for a free data slot not claimed by a pending bus write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_have_q <= 1'b0;
      araddr_q <= '0;
      rvalid_q <= 1'b0;
      rdata_q <= `WORD_ZERO;
      rresp_q <= `RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        ar_have_q <= 1'b1;
        araddr_q <= araddr;
      end
      if (axi_rd_go) begin
        ar_have_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= (axi_idx > `IDX_CONTROL) ? `RESP_SLVERR : `RESP_OKAY;
        if (!axi_idx[`IDX_OWN_BIT]) begin
          rdata_q <= {24'h000000, acc_rdata};
        end else if (axi_idx == `IDX_PROG_ADDR) begin
          rdata_q <= {20'h00000, prog_addr_q};
        end else if (axi_idx == `IDX_CONTROL) begin
          rdata_q <= {29'h0000000, phase_q, run_q};
        end else begin
          rdata_q <= `WORD_ZERO;
        end
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign awready = !aw_have_q;
  assign wready = !w_have_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = !ar_have_q && !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign program_counter = pc_q;
  assign instr_word = instr_q;
  assign instr_valid = instr_valid_q;
  assign operand_data = operand_q;
  assign operand_valid = operand_valid_q;
  assign bank_select = status_q[`STATUS_RP_HI:`STATUS_RP_LO];
  assign interrupt_control = interrupt_control_q;

  property p_reset_vector;
    $rose(aresetn) |-> pc_q == `RESET_VECTOR && instr_valid_q == 1'b0;
  endproperty
  a_reset_vector: assert property (p_reset_vector) // RULE4
    else $error("pc not at reset vector after reset");

  property p_irq_vector;
    (ce && run_q && phase_q == banked_memory_pkg::PH_Q1 && irq_take)
      |=> pc_q == `IRQ_VECTOR;
  endproperty
  a_irq_vector: assert property (p_irq_vector) // RULE5
    else $error("interrupt did not load vector");

  property p_pc_step;
    (ce && run_q && phase_q == banked_memory_pkg::PH_Q1 && !irq_take &&
     !branch_valid && !pcl_wr) |=> pc_q == $past(pc_q) + `PC_ONE;
  endproperty
  a_pc_step: assert property (p_pc_step) // RULE1
    else $error("pc did not advance by one");

  property p_fetch_wrap;
    (ce && run_q && phase_q == banked_memory_pkg::PH_Q1)
      |=> fetch_addr == $past(pc_q[`PROG_AW-1:0]);
  endproperty
  a_fetch_wrap: assert property (p_fetch_wrap) // RULE3
    else $error("fetch not taken from wrapped address");

  property p_bank_sel;
    (core_slot && data_req.addr != `SFR_INDIRECT) |->
      acc_eff[`DADDR_W-1:`OFF_W] == status_q[`STATUS_RP_HI:`STATUS_RP_LO];
  endproperty
  a_bank_sel: assert property (p_bank_sel) // RULE7
    else $error("direct access used wrong bank");

  property p_indirect;
    (core_slot && data_req.addr == `SFR_INDIRECT) |->
      acc_eff[7:0] == fsr_q && acc_eff[`DADDR_W-1] == status_q[`STATUS_IRP];
  endproperty
  a_indirect: assert property (p_indirect) // RULE10
    else $error("indirect access ignored pointer");

  property p_common;
    (acc_eff[`DADDR_W-1:`OFF_W] != `BANK0 &&
     acc_eff[`OFF_W-1:0] >= `COMMON_LO) |->
      dec.kind == banked_memory_pkg::TGT_GPR &&
      dec.index == `GPR_IDX_W'(acc_eff[`OFF_W-1:0] - `GPR_LO);
  endproperty
  a_common: assert property (p_common) // RULE12
    else $error("top bytes not mapped onto bank 0");

  property p_mirror;
    (acc_eff[`OFF_W-1:0] == `SFR_STATUS) |-> acc_rdata == status_q;
  endproperty
  a_mirror: assert property (p_mirror) // RULE9
    else $error("status not mirrored in this bank");

  property p_q_slots;
    (ce && operand_valid_q) |-> $past(phase_q) == banked_memory_pkg::PH_Q2
      ##0 (!(core_slot && acc_we) ||
           phase_q == banked_memory_pkg::PH_Q4);
  endproperty
  a_q_slots: assert property (p_q_slots) // RULE13
    else $error("data access outside its quarter cycle");

  property p_unmapped;
    (dec.kind == banked_memory_pkg::TGT_NONE) |->
      acc_rdata == `BYTE_ZERO && !ram_we && !pcl_wr;
  endproperty
  a_unmapped: assert property (p_unmapped) // RULE14
    else $error("unmapped address had an effect");

endmodule : banked_memory_address_map

//--- sim/core_model.sv
// Behavioural core for the address map: holds data requests and
// branch or interrupt requests for one instruction cycle at a time.
// Assumes the map pulses instr_valid once per instruction cycle.
`timescale 1ns/1ps
`include "banked_memory_cfg.svh"

module core_model (
  input wire logic aclk,
  input wire logic instr_valid,
  input wire logic [`INSTR_W-1:0] instr_word,
  input wire logic operand_valid,
  input wire logic [7:0] operand_data,
  output logic branch_valid,
  output logic [`PC_W-1:0] branch_target,
  output logic irq_take,
  output banked_memory_pkg::data_req_t data_req
);
  logic [7:0] last_operand;

  initial begin
    branch_valid = 1'b0;
    branch_target = 13'h0000;
    irq_take = 1'b0;
    data_req = '0;
    last_operand = 8'h00;
  end

  // Keep the latest operand for the bench to judge
  always @(posedge aclk) begin
    if (operand_valid === 1'b1) begin
      last_operand <= operand_data;
    end
  end

  // request held whole cycle
  // Unused fields toggle so a stale value is never read as valid
  task automatic step(input logic bv, input logic [`PC_W-1:0] tgt,
                      input logic irq, input logic [6:0] a,
                      input logic wr, input logic [7:0] wd,
                      output logic [`INSTR_W-1:0] word);
    @(posedge aclk iff instr_valid === 1'b1);
    word = instr_word;
    branch_valid <= bv;
    branch_target <= bv ? tgt : ~branch_target;
    irq_take <= irq;
    data_req <= '{addr: a, write: wr, wdata: wr ? wd : ~data_req.wdata};
  endtask : step
endmodule : core_model

//--- sim/banked_memory_address_map_tb.sv
// Self-checking bench: register bus master plus a core model.
// Assumes the map answers the bus and pulses fetch and operand results.
`timescale 1ns/1ps
`include "banked_memory_cfg.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module banked_memory_address_map_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic branch_valid;
  logic [12:0] branch_target;
  logic irq_take;
  banked_memory_pkg::data_req_t data_req;
  logic [12:0] program_counter;
  logic [11:0] fetch_addr;
  logic [13:0] instr_word;
  logic instr_valid;
  logic [7:0] operand_data;
  logic operand_valid;
  logic [1:0] bank_select;
  logic [7:0] interrupt_control;
  int num_errors = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [13:0] word;

  // Free-running 25 MHz clock
  always #20 aclk = ~aclk;

  banked_memory_address_map u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .branch_valid(branch_valid), .branch_target(branch_target),
    .irq_take(irq_take), .data_req(data_req),
    .program_counter(program_counter), .fetch_addr(fetch_addr),
    .instr_word(instr_word), .instr_valid(instr_valid),
    .operand_data(operand_data), .operand_valid(operand_valid),
    .bank_select(bank_select), .interrupt_control(interrupt_control)
  );

  core_model u_core (
    .aclk(aclk), .instr_valid(instr_valid), .instr_word(instr_word),
    .operand_valid(operand_valid), .operand_data(operand_data),
    .branch_valid(branch_valid), .branch_target(branch_target),
    .irq_take(irq_take), .data_req(data_req)
  );

  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  // Read one word and compare it
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rready <= 1'b0;
    `CHK(rd, exp)
  endtask : rd_chk

  task automatic t_reset;
    rd_chk(12'h00C, 32'h0000_0018);
    `CHK(program_counter, 13'h0000)
    `CHK(bank_select, 2'h0)
    $display("reset test done");
  endtask : t_reset

  task automatic t_banks;
    logic [11:0] a;
    axi_wr(12'h00C, 32'h0000_0078);
    `CHK(bank_select, 2'h3)
    rd_chk(12'h60C, 32'h0000_0078);
    axi_wr(12'h410, 32'h0000_00F0);
    rd_chk(12'h010, 32'h0000_00F0);
    axi_wr(12'h1C0, 32'h0000_00C3);
    rd_chk(12'h3C0, 32'h0000_00C3);
    // Top sixteen bytes of each upper bank land in bank 0
    for (int b = 1; b < 4; b++) begin
      a = 12'h1C0 + 12'(b * 4) + 12'(b) * 12'h200;
      axi_wr(a, 32'h0000_0040 + 32'(b));
      rd_chk(12'h1C0 + 12'(b * 4), 32'h0000_0040 + 32'(b));
    end
    $display("bank test done");
  endtask : t_banks

  task automatic t_map;
    axi_wr(12'h280, 32'h0000_0011);
    rd_chk(12'h280, 32'h0000_0011);
    axi_wr(12'h480, 32'h0000_0022);
    rd_chk(12'h480, 32'h0000_0000);
    rd_chk(12'h004, 32'h0000_0000);
    axi_wr(12'h80C, 32'h0000_0001);
    `CHK(rs, `RESP_SLVERR)
    axi_wr(12'h02C, 32'h0000_00A5);
    `CHK(interrupt_control, 8'hA5)
    rd_chk(12'h62C, 32'h0000_00A5);
    $display("map test done");
  endtask : t_map

  task automatic t_program;
    axi_wr(12'h800, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      axi_wr(12'h804, 32'h0000_1000 + 32'(i));
    end
    axi_wr(12'h00C, 32'h0000_0038);
    `CHK(bank_select, 2'h1)
    axi_wr(12'h808, 32'h0000_0001);
    // Branch and interrupt requests reach the pc one cycle later and the
    // fetch from the new pc one cycle after that
    u_core.step(1'b1, 13'h1005, 1'b0, 7'h20, 1'b0, 8'h00, word);
    `CHK(word, 14'h1000)
    u_core.step(1'b0, 13'h0000, 1'b1, 7'h00, 1'b0, 8'h00, word);
    `CHK(word, 14'h1001)
    `CHK(u_core.last_operand, 8'h11)
    u_core.step(1'b0, 13'h0000, 1'b0, 7'h21, 1'b1, 8'h77, word);
    `CHK(word, 14'h1002)
    `CHK(program_counter, 13'h1005)
    `CHK(u_core.last_operand, 8'hC3)
    u_core.step(1'b0, 13'h0000, 1'b0, 7'h21, 1'b0, 8'h00, word);
    `CHK(word, 14'h1005)
    `CHK(fetch_addr, 12'h005)
    `CHK(program_counter, 13'h0004)
    u_core.step(1'b0, 13'h0000, 1'b0, 7'h21, 1'b0, 8'h00, word);
    `CHK(word, 14'h1004)
    `CHK(u_core.last_operand, 8'h77)
    axi_wr(12'h808, 32'h0000_0000);
    rd_chk(12'h284, 32'h0000_0077);
    axi_wr(12'h028, 32'h0000_001F);
    axi_wr(12'h008, 32'h0000_0034);
    `CHK(program_counter, 13'h1F34)
    rd_chk(12'h208, 32'h0000_0034);
    $display("program test done");
  endtask : t_program

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_banks();
    t_map();
    t_program();
    summarize();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
endmodule : banked_memory_address_map_tb
